// [logic/sltst_pkg.sv]
package sltst_pkg;
	// Register byte addresses (printed offsets are not multiples of four,
	// so each printed offset is an index and the address is four times it)
	localparam logic [11:0] SLTST_IDX_CUR_MODE = 12'h8CE;
	localparam logic [11:0] SLTST_IDX_MODE_REQ = 12'h8CF;
	localparam logic [11:0] SLTST_IDX_MODE_RES = 12'h8D0;
	localparam logic [11:0] SLTST_IDX_TEST_RES = 12'h8D2;
	localparam logic [11:0] SLTST_IDX_CTRL = 12'h900;
	localparam logic [11:0] SLTST_IDX_IRQ_STAT = 12'h901;
	localparam logic [11:0] SLTST_IDX_IRQ_MASK = 12'h902;
	localparam logic [11:0] SLTST_IDX_LEDS = 12'h903;

	// Operating modes
	localparam logic [15:0] SLTST_MODE_PARAM = 16'h0001;
	localparam logic [15:0] SLTST_MODE_DIAG = 16'h0002;
	localparam logic [15:0] SLTST_MODE_COMM = 16'h0003;
	localparam logic [15:0] SLTST_RESET_MODE = 16'h0003;

	// Mode change outcome codes
	localparam logic [15:0] SLTST_RES_OK = 16'h0000;
	localparam logic [15:0] SLTST_RES_BAD_MODE = 16'h0001;

	// Self-test result codes
	localparam logic [15:0] SLTST_TEST_PASS = 16'h07FF;
	localparam logic [15:0] SLTST_TEST_FAIL_BASE = 16'hF700;
	localparam logic [15:0] SLTST_TEST_NONE = 16'h0000;
	localparam int SLTST_NUM_STEPS = 6;

	// Timing
	localparam int SLTST_CLK_HZ = 100_000_000;
	localparam int SLTST_DIAG_S = 15;
	localparam longint SLTST_DIAG_CYC = longint'(SLTST_DIAG_S) * SLTST_CLK_HZ;
	localparam int SLTST_BLINK_MS = 250;
	localparam int SLTST_BLINK_CYC = SLTST_BLINK_MS * (SLTST_CLK_HZ / 1000);
	localparam int SLTST_PULSE_MS = 50;
	localparam int SLTST_PULSE_CYC = SLTST_PULSE_MS * (SLTST_CLK_HZ / 1000);

	// Interrupt status bits
	localparam int SLTST_IRQ_MODE_DONE = 0;
	localparam int SLTST_IRQ_TEST_PASS = 1;
	localparam int SLTST_IRQ_TEST_FAIL = 2;
	localparam int SLTST_IRQ_HW_FAULT = 3;
	localparam int SLTST_IRQ_W = 4;

	typedef struct packed {
		logic run;
		logic link_activity;
		logic parameter_mode;
		logic token;
		logic error;
		logic comm_error;
		logic ready;
		logic self_test;
	} sltst_leds_t;

	typedef struct packed {
		logic watchdog_fault;
		logic module_error;
		logic comm_error;
		logic ready;
		logic params_invalid;
		logic cyclic_active;
		logic acyclic_event;
		logic token_held;
		logic multi_master;
		logic low_rate;
		logic flash_init;
	} sltst_status_t;

	typedef struct packed {
		logic [SLTST_NUM_STEPS-1:0] fail;
	} sltst_diag_t;

	localparam logic [15:0] SLTST_DEFAULT_DCT = 16'h0010;
endpackage

// [logic/sltst_blink.sv]
`timescale 1ns/100ps
// Free-running toggle driven from a one-cycle enable
module sltst_blink
	import sltst_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// Control
	input wire logic tick_i,
	input wire logic [15:0] period_i,
	// Output
	output logic phase_o
);
	logic [15:0] cnt_q;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q <= 16'h0000;
			phase_o <= 1'b0;
		end else if (tick_i) begin
			if (cnt_q >= period_i) begin
				cnt_q <= 16'h0000;
				phase_o <= ~phase_o;
			end else begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end
endmodule // sltst_blink

// [logic/sltst_top.sv]
// Design decision made here: the APB register port.
`timescale 1ns/100ps
// Operation
// R1: Run LED on normally, off on watchdog or hardware fault.
// R2: Activity LED flashes during cyclic or acyclic traffic, dark otherwise.
// R3: Cyclic flash period from data control time; acyclic one flash per frame.
// R4: Parameter LED on in mode 1, flashes if parameters invalid, else off.
// R5: Token LED steady for one master; multi-master flashes at low rates.
// R6: Error LED on while any module error is present.
// R7: Communication error LED on while a communication error exists.
// R8: Ready LED on when able to communicate or communicating.
// R9: Self-test LED on or flashing in diagnostics, on during flash init.
// R10: Whole diagnostic sequence ends within about fifteen seconds.
// R11: Host writes 2 into mode request word, then raises request.
// R12: Entering mode 2 starts diagnostics without further request.
// R13: Result code stored at end; pass clears self-test LED, fail lights both.
// R14: Pass code 07FF; F700 to F705 name the failed step.
// R15: Host may start cyclic exchange with the exchange start request.
// R16: Mode change outcome stored, then completion handshake raised.
// R17: Successful mode change updates the current mode word.
// R18: Host waits for completion before a new request, then drops it.
module sltst_top
	import sltst_pkg::*;
#(
	parameter longint DIAG_CYCLES = SLTST_DIAG_CYC,
	parameter int BLINK_CYCLES = SLTST_BLINK_CYC,
	parameter int PULSE_CYCLES = SLTST_PULSE_CYC
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [15:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Host handshakes
	input wire logic mode_change_req_i,
	output logic mode_change_done_o,
	input wire logic exchange_start_request_signal_i,
	output logic exchange_running_o,
	// Module status from the protocol engine and diagnostics hardware
	input wire sltst_status_t status_i,
	input wire sltst_diag_t diag_i,
	// Indicators and interrupt
	output sltst_leds_t leds_o,
	output logic irq_o
);
	typedef enum {ST_IDLE, ST_DIAG, ST_DONE} sltst_state_t;

	function automatic logic addr_is(input logic [15:0] a,
			input logic [11:0] idx);
		addr_is = (a[15:2] == {2'b00, idx});
	endfunction

	// Synchronised pin inputs
	sltst_status_t st_s1_q, st_q;
	sltst_diag_t dg_s1_q, dg_q;
	logic [1:0] req_s_q, xs_s_q;
	logic req_prev_q;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_s1_q <= '0;
			st_q <= '0;
			dg_s1_q <= '0;
			dg_q <= '0;
			req_s_q <= 2'b00;
			xs_s_q <= 2'b00;
			req_prev_q <= 1'b0;
		end else begin
			st_s1_q <= status_i;
			st_q <= st_s1_q;
			dg_s1_q <= diag_i;
			dg_q <= dg_s1_q;
			req_s_q <= {req_s_q[0], mode_change_req_i};
			xs_s_q <= {xs_s_q[0], exchange_start_request_signal_i};
			req_prev_q <= req_s_q[1];
		end
	end

	wire logic req_rise = req_s_q[1] & ~req_prev_q;
	wire logic apb_acc = psel_i & penable_i;
	wire logic apb_wr = apb_acc & pwrite_i;
	wire logic apb_rd = apb_acc & ~pwrite_i;

	// Registers
	logic [15:0] cur_mode_q, mode_req_q, mode_res_q, test_res_q, dct_q;
	logic [SLTST_IRQ_W-1:0] irq_stat_q, irq_mask_q;
	logic mode_done_q;
	sltst_state_t state_q;
	longint diag_cnt_q;
	logic [SLTST_IRQ_W-1:0] ev;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_req_q <= 16'h0000;
			dct_q <= SLTST_DEFAULT_DCT;
			irq_mask_q <= '0;
		end else if (apb_wr) begin
			if (addr_is(paddr_i, SLTST_IDX_MODE_REQ))
				mode_req_q <= pwdata_i[15:0]; // [R11]
			if (addr_is(paddr_i, SLTST_IDX_CTRL))
				dct_q <= pwdata_i[15:0];
			if (addr_is(paddr_i, SLTST_IDX_IRQ_MASK))
				irq_mask_q <= pwdata_i[SLTST_IRQ_W-1:0];
		end
	end

	// Mode change handling: outcome first, completion one cycle later
	logic res_valid_q;
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cur_mode_q <= SLTST_RESET_MODE;
			mode_res_q <= SLTST_RES_OK;
			res_valid_q <= 1'b0;
			mode_done_q <= 1'b0;
		end else begin
			res_valid_q <= 1'b0;
			if (!req_s_q[1]) begin
				mode_done_q <= 1'b0; // [R18]
			end else if (res_valid_q) begin
				mode_done_q <= 1'b1; // [R16]
			end
			if (req_rise && !mode_done_q) begin
				res_valid_q <= 1'b1;
				if (mode_req_q >= SLTST_MODE_PARAM &&
						mode_req_q <= SLTST_MODE_COMM) begin
					mode_res_q <= SLTST_RES_OK; // [R16]
					cur_mode_q <= mode_req_q; // [R17]
				end else begin
					mode_res_q <= SLTST_RES_BAD_MODE; // [R16]
				end
			end
		end
	end

	// Self-diagnostic sequencer; one counter times the whole run, and any failed step ends it early
	wire logic enter_diag = res_valid_q && cur_mode_q == SLTST_MODE_DIAG &&
		mode_res_q == SLTST_RES_OK;
	logic [15:0] fail_code;
	logic any_fail;
	always_comb begin
		fail_code = SLTST_TEST_PASS;
		any_fail = 1'b0;
		for (int i = SLTST_NUM_STEPS - 1; i >= 0; i--) begin
			if (dg_q.fail[i]) begin
				fail_code = SLTST_TEST_FAIL_BASE + 16'(i); // [R14]
				any_fail = 1'b1;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= ST_IDLE;
			diag_cnt_q <= 0;
			test_res_q <= SLTST_TEST_NONE;
		end else begin
			case (state_q)
				ST_IDLE, ST_DONE: begin
					if (enter_diag) begin
						state_q <= ST_DIAG; // [R12]
						diag_cnt_q <= 0;
					end else if (cur_mode_q != SLTST_MODE_DIAG) begin
						state_q <= ST_IDLE;
					end
				end
				ST_DIAG: begin
					if (any_fail || diag_cnt_q >= DIAG_CYCLES - 1) begin
						test_res_q <= fail_code; // [R13] [R10]
						state_q <= ST_DONE;
					end else begin
						diag_cnt_q <= diag_cnt_q + 1;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
	wire logic diag_fail = (state_q == ST_DONE) &&
		(test_res_q != SLTST_TEST_PASS);

	// Interrupt status: hardware set wins over read clear
	always_comb begin
		ev = '0;
		ev[SLTST_IRQ_MODE_DONE] = res_valid_q;
		ev[SLTST_IRQ_TEST_PASS] = state_q == ST_DIAG && !any_fail &&
			diag_cnt_q >= DIAG_CYCLES - 1;
		ev[SLTST_IRQ_TEST_FAIL] = state_q == ST_DIAG && any_fail;
		ev[SLTST_IRQ_HW_FAULT] = st_q.watchdog_fault;
	end
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i)
			irq_stat_q <= '0;
		else if (apb_rd && addr_is(paddr_i, SLTST_IDX_IRQ_STAT))
			irq_stat_q <= (irq_stat_q & ~prdata_o[SLTST_IRQ_W-1:0]) | ev;
		else
			irq_stat_q <= irq_stat_q | ev;
	end

	// Slow tick and blinkers
	logic tick_q;
	logic [31:0] tick_cnt_q;
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tick_cnt_q <= 32'h00000000;
			tick_q <= 1'b0;
		end else begin
			tick_q <= 1'b0;
			if (tick_cnt_q >= 32'(BLINK_CYCLES / 64 + 1)) begin
				tick_cnt_q <= 32'h00000000;
				tick_q <= 1'b1;
			end else begin
				tick_cnt_q <= tick_cnt_q + 32'h00000001;
			end
		end
	end

	logic slow_ph, dct_ph;
	sltst_blink u_slow (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.tick_i(tick_q),
		.period_i(16'h003F),
		.phase_o(slow_ph)
	);
	sltst_blink u_dct (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.tick_i(tick_q),
		.period_i(dct_q), // [R3]
		.phase_o(dct_ph)
	);

	// One visible flash per acyclic frame; a new frame restarts it
	logic acy_prev_q;
	logic [31:0] pulse_q;
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			acy_prev_q <= 1'b0;
			pulse_q <= 32'h00000000;
		end else begin
			acy_prev_q <= st_q.acyclic_event;
			if (st_q.acyclic_event && !acy_prev_q)
				pulse_q <= 32'(PULSE_CYCLES); // [R3]
			else if (pulse_q != 32'h00000000)
				pulse_q <= pulse_q - 32'h00000001;
		end
	end

	// Exchange start is held by the host as a level
	wire logic cyclic_on = st_q.cyclic_active &&
		cur_mode_q == SLTST_MODE_COMM;
	sltst_leds_t led_d;
	always_comb begin
		led_d.run = ~st_q.watchdog_fault; // [R1]
		if (cyclic_on)
			led_d.link_activity = dct_ph; // [R2] [R3]
		else
			led_d.link_activity = pulse_q != 32'h00000000; // [R2]
		if (cur_mode_q != SLTST_MODE_PARAM)
			led_d.parameter_mode = 1'b0; // [R4]
		else if (st_q.params_invalid)
			led_d.parameter_mode = slow_ph; // [R4]
		else
			led_d.parameter_mode = 1'b1; // [R4]
		if (!st_q.token_held)
			led_d.token = 1'b0;
		else if (st_q.multi_master && st_q.low_rate)
			led_d.token = slow_ph; // [R5]
		else
			led_d.token = 1'b1; // [R5]
		led_d.error = st_q.module_error | diag_fail; // [R6] [R13]
		led_d.comm_error = st_q.comm_error; // [R7]
		led_d.ready = st_q.ready | cyclic_on; // [R8]
		led_d.self_test = (state_q == ST_DIAG) | diag_fail |
			st_q.flash_init; // [R9] [R13]
	end

	// Read mux
	logic [31:0] rd_d;
	always_comb begin
		rd_d = 32'h00000000;
		if (addr_is(paddr_i, SLTST_IDX_CUR_MODE))
			rd_d = {16'h0000, cur_mode_q};
		else if (addr_is(paddr_i, SLTST_IDX_MODE_REQ))
			rd_d = {16'h0000, mode_req_q};
		else if (addr_is(paddr_i, SLTST_IDX_MODE_RES))
			rd_d = {16'h0000, mode_res_q};
		else if (addr_is(paddr_i, SLTST_IDX_TEST_RES))
			rd_d = {16'h0000, test_res_q};
		else if (addr_is(paddr_i, SLTST_IDX_CTRL))
			rd_d = {16'h0000, dct_q};
		else if (addr_is(paddr_i, SLTST_IDX_IRQ_STAT))
			rd_d = {28'h0000000, irq_stat_q};
		else if (addr_is(paddr_i, SLTST_IDX_IRQ_MASK))
			rd_d = {28'h0000000, irq_mask_q};
		else if (addr_is(paddr_i, SLTST_IDX_LEDS))
			rd_d = {24'h000000, leds_o};
	end

	// Zero-wait APB; unmapped addresses answer with an error
	wire logic mapped = rd_d != 32'h00000000 ||
		addr_is(paddr_i, SLTST_IDX_CUR_MODE) ||
		addr_is(paddr_i, SLTST_IDX_MODE_REQ) ||
		addr_is(paddr_i, SLTST_IDX_MODE_RES) ||
		addr_is(paddr_i, SLTST_IDX_TEST_RES) ||
		addr_is(paddr_i, SLTST_IDX_CTRL) ||
		addr_is(paddr_i, SLTST_IDX_IRQ_STAT) ||
		addr_is(paddr_i, SLTST_IDX_IRQ_MASK) ||
		addr_is(paddr_i, SLTST_IDX_LEDS);
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prdata_o <= 32'h00000000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= psel_i & ~penable_i;
			pslverr_o <= psel_i & ~penable_i & ~mapped;
			if (psel_i & ~penable_i & ~pwrite_i)
				prdata_o <= rd_d;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			leds_o <= '0;
			irq_o <= 1'b0;
			mode_change_done_o <= 1'b0;
			exchange_running_o <= 1'b0;
		end else begin
			leds_o <= led_d;
			irq_o <= |(irq_stat_q & irq_mask_q);
			mode_change_done_o <= mode_done_q;
			exchange_running_o <= xs_s_q[1] &&
				cur_mode_q == SLTST_MODE_COMM; // [R15]
		end
	end
endmodule // sltst_top

// [tb/sltst_props.sv]
`timescale 1ns/100ps
module sltst_props
	import sltst_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// Bus and handshake
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pready_o,
	input wire logic mode_change_req_i,
	input wire logic mode_change_done_o,
	// Status and indicators
	input wire sltst_status_t status_i,
	input wire sltst_leds_t leds_o,
	input wire logic irq_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);

	// Status passes a synchroniser, so six stable cycles are allowed
	a_run_fault: assert property (
		$stable(status_i.watchdog_fault) [*6] |->
		leds_o.run == !status_i.watchdog_fault) else $error("run led wrong");
	a_error_on: assert property (
		status_i.module_error [*6] |-> leds_o.error)
		else $error("error led dark");
	a_comm_err: assert property (
		$stable(status_i.comm_error) [*6] |->
		leds_o.comm_error == status_i.comm_error) else $error("comm led wrong");
	a_ready_led: assert property (
		status_i.ready [*6] |-> leds_o.ready) else $error("ready led dark");
	a_ready_off: assert property (
		(!status_i.ready && !status_i.cyclic_active) [*6] |-> !leds_o.ready)
		else $error("ready led lit");
	a_token_off: assert property (
		!status_i.token_held [*6] |-> !leds_o.token)
		else $error("token led lit");
	a_token_one: assert property (
		(status_i.token_held && !status_i.multi_master) [*6] |-> leds_o.token)
		else $error("token led not steady");
	a_done_rise: assert property (
		$rose(mode_change_req_i) && !mode_change_done_o |->
		##[3:12] mode_change_done_o) else $error("mode change not done");
	a_done_hold: assert property (
		mode_change_done_o && mode_change_req_i |=> mode_change_done_o)
		else $error("done dropped early");
	a_done_cause: assert property (
		$rose(mode_change_done_o) |-> $past(mode_change_req_i, 2))
		else $error("done without request");
	a_apb_answer: assert property (
		psel_i && !penable_i |=> pready_o) else $error("no bus answer");

	c_mode_done: cover property ($rose(mode_change_done_o));
	c_irq: cover property ($rose(irq_o));
	c_test_end: cover property ($fell(leds_o.self_test));
endmodule // sltst_props

bind sltst_top sltst_props u_props (
	.clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel_i),
	.penable_i(penable_i), .pready_o(pready_o),
	.mode_change_req_i(mode_change_req_i),
	.mode_change_done_o(mode_change_done_o),
	.status_i(status_i), .leds_o(leds_o), .irq_o(irq_o)
);

// [tb/sltst_host_model.sv]
`timescale 1ns/100ps
// Host side of the mode change handshake
module sltst_host_model (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rstn_i,
	// Bench control
	input wire logic go_i,
	output logic busy_o,
	// Handshake
	input wire logic done_i,
	output logic req_o
);
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			req_o <= 1'b0;
		end else if (go_i && !busy_o) begin
			req_o <= 1'b1;
		end else if (done_i) begin
			req_o <= 1'b0;
		end
	end
	// Busy until completion falls, so requests never overlap
	assign busy_o = req_o | done_i;
endmodule // sltst_host_model

// [tb/test_sltst_top.sv]
`timescale 1ns/100ps
module test_sltst_top
	import sltst_pkg::*;
;
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic go = 1'b0;
	logic xreq = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h00000000;
	sltst_status_t status = '0;
	sltst_diag_t diag = '0;
	logic [31:0] prdata;
	logic pready, pslverr, req, done, xrun, irq, busy;
	sltst_leds_t leds;
	logic [32:0] exp_q[$];
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [15:0] r = 16'h34EB;

	initial begin
		forever #5 clock_i = ~clock_i;
	end

	sltst_top #(.DIAG_CYCLES(2000), .BLINK_CYCLES(640), .PULSE_CYCLES(20)) dut (
		.clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .mode_change_req_i(req),
		.mode_change_done_o(done), .exchange_start_request_signal_i(xreq),
		.exchange_running_o(xrun), .status_i(status), .diag_i(diag),
		.leds_o(leds), .irq_o(irq)
	);

	sltst_host_model host (.clock_i(clock_i), .rstn_i(rstn_i), .go_i(go),
		.busy_o(busy), .done_i(done), .req_o(req));

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		if (mismatches == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [11:0] idx,
		input logic [31:0] wd, input logic [32:0] exp);
		if (!wr) exp_q.push_back(exp);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= 16'({idx, 2'b00});
		pwdata <= wd;
		@(posedge clock_i);
		penable <= 1'b1;
		do @(posedge clock_i); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock_i);
	endtask

	task automatic mode_chg(input logic [15:0] m, res, cur, input logic stat);
		int n;
		apb(1'b1, SLTST_IDX_MODE_REQ, {16'h0000, m}, '0);
		go <= 1'b1;
		@(posedge clock_i);
		go <= 1'b0;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (busy === 1'b1 && n < 100);
		check(n < 100, 1'b1);
		apb(1'b0, SLTST_IDX_MODE_RES, '0, {17'h00000, res});
		apb(1'b0, SLTST_IDX_CUR_MODE, '0, {17'h00000, cur});
		if (stat) apb(1'b0, SLTST_IDX_IRQ_STAT, '0, 33'h000000001);
	endtask

	// Read answers are compared against notes in arrival order
	always @(posedge clock_i) begin
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
			check({pslverr, prdata}, exp_q.pop_front());
	end

	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			wrap_up();
		end
	end

	initial begin
		sltst_status_t st;
		int n;
		logic seen;
		int ones;
		repeat (20) @(posedge clock_i);
		rstn_i <= 1'b1;
		@(posedge clock_i);
		apb(1'b0, SLTST_IDX_CUR_MODE, '0, 33'h000000003);
		apb(1'b0, SLTST_IDX_TEST_RES, '0, 33'h000000000);
		apb(1'b0, 12'h7FF, '0, 33'h100000000);
		apb(1'b1, SLTST_IDX_IRQ_MASK, 32'h00000006, '0);
		apb(1'b0, SLTST_IDX_IRQ_MASK, '0, 33'h000000006);
		for (int i = 0; i < 6; i++) begin
			r = lfsr(r);
			st = sltst_status_t'(r[10:0]);
			st.acyclic_event = 1'b0;
			st.token_held = 1'b1;
			st.multi_master = i[0];
			st.watchdog_fault = i[1];
			status <= st;
			xreq <= r[11];
			repeat (30) @(posedge clock_i);
			check(leds.run, !st.watchdog_fault);
			check(leds.parameter_mode, 1'b0);
			if (!st.multi_master) check(leds.token, 1'b1);
			check(leds.error, st.module_error);
			check(leds.comm_error, st.comm_error);
			check(leds.ready, st.ready | st.cyclic_active);
			check(leds.self_test, st.flash_init);
			check(xrun, r[11]);
			check(irq, 1'b0);
		end
		status <= '0;
		repeat (40) @(posedge clock_i);
		check(leds.link_activity, 1'b0);
		status.acyclic_event <= 1'b1;
		repeat (6) @(posedge clock_i);
		check(leds.link_activity, 1'b1);
		status.acyclic_event <= 1'b0;
		repeat (30) @(posedge clock_i);
		check(leds.link_activity, 1'b0);
		// Cyclic traffic in mode 3: the light must spend time both on and off
		status.cyclic_active <= 1'b1;
		ones = 0;
		repeat (450) begin
			@(posedge clock_i);
			ones += leds.link_activity;
		end
		check(ones > 100 && ones < 350, 1'b1);
		status.cyclic_active <= 1'b0;
		repeat (10) @(posedge clock_i);
		apb(1'b0, SLTST_IDX_IRQ_STAT, '0, 33'h000000008);
		mode_chg(16'h0001, SLTST_RES_OK, 16'h0001, 1'b1);
		xreq <= 1'b1;
		repeat (8) @(posedge clock_i);
		check(leds.parameter_mode, 1'b1);
		check(xrun, 1'b0);
		mode_chg(16'h0005, SLTST_RES_BAD_MODE, 16'h0001, 1'b1);
		for (int k = 0; k <= 6; k++) begin
			mode_chg(16'h0003, SLTST_RES_OK, 16'h0003, 1'b1);
			diag.fail <= (k < 6) ? 6'(6'h3F << k) : 6'h00;
			mode_chg(16'h0002, SLTST_RES_OK, 16'h0002, 1'b0);
			n = 0;
			seen = 1'b0;
			do begin
				@(posedge clock_i);
				n++;
				seen |= leds.self_test;
			end while (irq !== 1'b1 && n < 3000);
			check(n < 2050, 1'b1);
			if (k == 6) check(seen, 1'b1);
			repeat (5) @(posedge clock_i);
			check(leds.self_test, k < 6);
			check(leds.error, k < 6);
			apb(1'b0, SLTST_IDX_TEST_RES, '0,
				(k < 6) ? 33'h00000F700 + k : 33'h0000007FF);
			apb(1'b0, SLTST_IDX_IRQ_STAT, '0, (k < 6) ? 33'h5 : 33'h3);
			repeat (2) @(posedge clock_i);
			check(irq, 1'b0);
		end
		wrap_up();
	end
endmodule // test_sltst_top
